/* File: spsf_cfg.svh */
// offsets, field positions, reset values and counts of the serial status flag block
`ifndef SPSF_CFG_SVH
`define SPSF_CFG_SVH
// ==========================================================
// register offsets
`define SPSF_OFF_STATUS  2'h0
`define SPSF_OFF_DATA    2'h1
`define SPSF_OFF_CTRL2   2'h2
`define SPSF_OFF_CTRL1   2'h3
// ==========================================================
// field positions
`define SPSF_C2_TE_BIT   3
`define SPSF_C2_SBK_BIT  0
`define SPSF_C1_M_BIT    4
`define SPSF_C1_ILT_BIT  2
`define SPSF_C1_PE_BIT   1
`define SPSF_C1_PT_BIT   0
`define SPSF_RX_MASK     8'h3F
// ==========================================================
// reset values
`define SPSF_FLAGS_RST   8'hC0
`define SPSF_CTRL_RST    8'h00
// ==========================================================
// timing counts
`define SPSF_SMP_PER_BIT 4'hF
`define SPSF_START_FIRST 4'h3
`define SPSF_MID_FIRST   4'h7
`define SPSF_SMP_LAST    4'h9
`define SPSF_CHAR_8      4'hA
`define SPSF_CHAR_9      4'hB
`endif

/* File: spsf_pkg.sv */
// types shared by the serial status flag block
package spsf_pkg;
   // ==========================================================
   // status flag layout, bit 7 down to bit 0
   typedef struct packed {
      logic txe;
      logic tc;
      logic rxf;
      logic idle;
      logic ovr;
      logic noise;
      logic frame;
      logic par;
   } spsf_flags_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } spsf_rx_state_t;
endpackage : spsf_pkg

/* File: spsf_top.sv */
// serial port status flags with receiver, transmitter and register port
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`include "spsf_cfg.svh"

// What this block does
// - status register holds eight read-only flags; writes ignored, clears only by sequences.
// - transmit-empty flag is 1 after reset and sets when buffer moves to shifter.
// - transmit-empty clears after status read seeing it set, then data write.
// - transmit-complete is 1 after reset and whenever buffer empty, shifter idle and no preamble or break queued.
// - armed transmit-complete clears on data write, transmitter enable rise, or break write.
// - receive-full sets when a character moves into the receive data register.
// - receive-full clears after status read seeing it set, then data read.
// - idle sets after one character time high: 10 bits, or 11 in 9-bit format.
// - idle count type 0 counts after start bit; 1 counts after stop bit.
// - idle clears after status read seeing it set, then data read.
// - idle sets again only after a new character made receive-full set.
// - overrun sets when previous character unread; new character and errors discarded.
// - overrun clears after status read seeing it set, then data read.
// - seven start samples, three per data and stop bit; disagreement sets noise.
// - noise clears after status read, then data read.
// - framing error sets with receive-full when stop bit samples as zero.
// - framing error clears after status read seeing it set, then data read.
// - with parity checking on, parity error sets with receive-full on mismatch.
// - parity error clears after status read, then data read.
// - parity kind 0 is even, 1 is odd, counting the parity bit itself.
module spsf_top
   import spsf_pkg::*;
#(
   parameter int SAMPLE_DIV = 16  // clock cycles per receive sample, sixteen samples a bit
) (
   input  wire logic       SYS_CLK_I,
   input  wire logic       RST_I,
   input  wire logic [1:0] ADDR_I,
   input  wire logic [7:0] WDATA_I,
   input  wire logic       WR_I,
   input  wire logic       RD_I,
   output logic      [7:0] RDATA_O,
   input  wire logic       RXD_I,
   output logic            TXD_O
);
   // ==========================================================
   // elaboration check
   if (SAMPLE_DIV < 1 || SAMPLE_DIV > 65535) begin : g_bad_div
      $error("SAMPLE_DIV out of range");
   end

   spsf_flags_t    flags_q;
   spsf_rx_state_t rx_st_q;
   logic [7:0]  arm_q, ctrl1_q, ctrl2_q, rx_data_q, tx_buf_q;
   logic [15:0] div_q;
   logic        tick;
   logic [3:0]  ph_q, cnt_q, bits_q, idle_cnt_q, char_len;
   logic [1:0]  smp_q;
   logic [8:0]  rx_sh_q;
   logic        rx_par_q, rx_noise_q, allow_q;
   logic [10:0] tx_sh_q;
   logic [3:0]  tx_left_q, tx_ph_q;
   logic        tx_active, tx_load, pre_q, txd_q, te_rise;
   logic        st_rd, dat_rd, dat_wr, c2_wr, sbk_on;
   logic [7:0]  clr;
   logic        rx_done, stop_bit, rxf_eff, mid_smp, maj, dis;

   // ==========================================================
   // bus decode and control registers
   assign st_rd    = RD_I && ADDR_I == `SPSF_OFF_STATUS;
   assign dat_rd   = RD_I && ADDR_I == `SPSF_OFF_DATA;
   assign dat_wr   = WR_I && ADDR_I == `SPSF_OFF_DATA;
   assign c2_wr    = WR_I && ADDR_I == `SPSF_OFF_CTRL2;
   assign te_rise  = c2_wr && WDATA_I[`SPSF_C2_TE_BIT] && !ctrl2_q[`SPSF_C2_TE_BIT];
   assign sbk_on   = ctrl2_q[`SPSF_C2_SBK_BIT];
   assign char_len = ctrl1_q[`SPSF_C1_M_BIT] ? `SPSF_CHAR_9 : `SPSF_CHAR_8;

   // writes to the status offset fall through: nothing stores them
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ctrl1_q <= `SPSF_CTRL_RST;
         ctrl2_q <= `SPSF_CTRL_RST;
      end else if (WR_I) begin
         if (ADDR_I == `SPSF_OFF_CTRL1) ctrl1_q <= WDATA_I;
         if (ADDR_I == `SPSF_OFF_CTRL2) ctrl2_q <= WDATA_I;
      end
   end

   // read data stands for the single cycle after the strobe
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         RDATA_O <= 8'h00;
      end else if (RD_I) begin
         unique case (ADDR_I)
            `SPSF_OFF_STATUS: RDATA_O <= flags_q;
            `SPSF_OFF_DATA:   RDATA_O <= rx_data_q;
            `SPSF_OFF_CTRL2:  RDATA_O <= ctrl2_q;
            `SPSF_OFF_CTRL1:  RDATA_O <= ctrl1_q;
         endcase
      end else begin
         RDATA_O <= 8'h00;
      end
   end

   // ==========================================================
   // clear sequences: a status read arms what it saw
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         arm_q <= 8'h00;
      end else if (st_rd) begin
         arm_q <= flags_q;
      end else begin
         arm_q <= arm_q & ~clr;
      end
   end

   // which armed flags the current access consumes
   always_comb begin
      clr = 8'h00;
      if (dat_rd) clr = arm_q & `SPSF_RX_MASK;
      if (dat_wr) clr[7:6] = arm_q[7:6];
      if (te_rise || (c2_wr && WDATA_I[`SPSF_C2_SBK_BIT])) clr[6] = arm_q[6];
   end

   // ==========================================================
   // sample enable divider
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         div_q <= 16'h0000;
      end else if (div_q == 16'(SAMPLE_DIV - 1)) begin
         div_q <= 16'h0000;
      end else begin
         div_q <= div_q + 16'h0001;
      end
   end
   assign tick = div_q == 16'(SAMPLE_DIV - 1);

   // ==========================================================
   // receiver: majority of three mid-bit samples, noise on any disagreement
   assign mid_smp  = ph_q >= `SPSF_MID_FIRST && ph_q <= `SPSF_SMP_LAST;
   assign maj      = (smp_q[1] & smp_q[0]) | (RXD_I & (smp_q[1] | smp_q[0]));
   assign dis      = !((smp_q[1] & smp_q[0] & RXD_I) | !(smp_q[1] | smp_q[0] | RXD_I));
   assign stop_bit = maj;
   assign rx_done  = tick && rx_st_q == RX_STOP && ph_q == `SPSF_SMP_LAST;
   assign rxf_eff  = flags_q.rxf && !clr[5];

   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rx_st_q    <= RX_IDLE;
         ph_q       <= 4'h0;
         cnt_q      <= 4'h0;
         bits_q     <= 4'h0;
         smp_q      <= 2'h0;
         rx_sh_q    <= 9'h000;
         rx_par_q   <= 1'b0;
         rx_noise_q <= 1'b0;
      end else if (tick) begin
         ph_q <= ph_q + 4'h1;
         if (mid_smp) smp_q <= {smp_q[0], RXD_I};
         unique case (rx_st_q)
            RX_IDLE: if (!RXD_I) begin
               rx_st_q    <= RX_START;
               ph_q       <= 4'h1;
               cnt_q      <= 4'h0;
               bits_q     <= 4'h0;
               rx_par_q   <= 1'b0;
               rx_noise_q <= 1'b0;
            end
            RX_START: begin
               // seven samples, phases three to nine
               if (ph_q >= `SPSF_START_FIRST && ph_q <= `SPSF_SMP_LAST)
                  cnt_q <= cnt_q + {3'h0, RXD_I};
               if (ph_q == `SPSF_SMP_LAST) begin
                  if (cnt_q + {3'h0, RXD_I} != 4'h0) rx_noise_q <= 1'b1;
                  if (cnt_q + {3'h0, RXD_I} > 4'h3) rx_st_q <= RX_IDLE;  // false start
               end
               if (ph_q == `SPSF_SMP_PER_BIT) rx_st_q <= RX_DATA;
            end
            RX_DATA: begin
               if (ph_q == `SPSF_SMP_LAST) begin
                  rx_sh_q  <= {maj, rx_sh_q[8:1]};
                  rx_par_q <= rx_par_q ^ maj;
                  if (dis) rx_noise_q <= 1'b1;
                  bits_q   <= bits_q + 4'h1;
               end
               if (ph_q == `SPSF_SMP_PER_BIT && bits_q == char_len - 4'h2)
                  rx_st_q <= RX_STOP;
            end
            RX_STOP: if (ph_q == `SPSF_SMP_LAST) begin
               // hand back early so the next start edge is not missed
               rx_st_q <= RX_IDLE;
               ph_q    <= 4'h0;
            end
         endcase
      end
   end

   // ==========================================================
   // idle line counter, one count per bit time of high line
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         idle_cnt_q <= 4'h0;
      end else if (rx_st_q == RX_START || (tick && !RXD_I)) begin
         idle_cnt_q <= 4'h0;
      end else if (rx_st_q != RX_IDLE && ctrl1_q[`SPSF_C1_ILT_BIT]) begin
         idle_cnt_q <= 4'h0;
      end else if (tick && ph_q == `SPSF_SMP_PER_BIT && idle_cnt_q != char_len) begin
         idle_cnt_q <= idle_cnt_q + 4'h1;
      end
   end

   // idle may set once per received character
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         allow_q <= 1'b0;
      end else if (rx_done && !rxf_eff) begin
         allow_q <= 1'b1;
      end else if (idle_cnt_q == char_len) begin
         allow_q <= 1'b0;
      end
   end

   // ==========================================================
   // status flags: clears first so a same-cycle set wins, except for transmit-complete
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         flags_q <= `SPSF_FLAGS_RST;
      end else begin
         flags_q <= flags_q & ~clr;
         // empty again only on the tick at which the shifter really takes the buffer
         if (tx_load) flags_q.txe <= 1'b1;
         // each clearing action starts new activity, so for this level the clear wins
         if (flags_q.txe && !tx_active && !pre_q && !sbk_on && !clr[6])
            flags_q.tc <= 1'b1;
         if (allow_q && idle_cnt_q == char_len) flags_q.idle <= 1'b1;
         if (rx_done) begin
            if (rxf_eff) begin
               flags_q.ovr <= 1'b1;
            end else begin
               flags_q.rxf   <= 1'b1;
               flags_q.noise <= rx_noise_q | dis;
               flags_q.frame <= !stop_bit;
               flags_q.par   <= ctrl1_q[`SPSF_C1_PE_BIT]
                                && (rx_par_q ^ ctrl1_q[`SPSF_C1_PT_BIT]);
            end
         end
      end
   end

   // received character, left alone on overrun
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rx_data_q <= 8'h00;
      end else if (rx_done && !rxf_eff) begin
         rx_data_q <= ctrl1_q[`SPSF_C1_M_BIT] ? rx_sh_q[7:0] : rx_sh_q[8:1];
      end
   end

   // ==========================================================
   // transmitter: preamble first, then break, then buffered data
   assign tx_active = tx_left_q != 4'h0;
   // data goes only when no preamble or break is queued ahead of it
   assign tx_load   = tick && !tx_active && ctrl2_q[`SPSF_C2_TE_BIT] && !pre_q && !sbk_on
                      && !flags_q.txe;

   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         tx_buf_q <= 8'h00;
         pre_q    <= 1'b0;
      end else begin
         if (dat_wr) tx_buf_q <= WDATA_I;
         if (te_rise) pre_q <= 1'b1;
         else if (!tx_active && tick) pre_q <= 1'b0;
      end
   end

   // shifter loads on a sample tick so bit edges follow the sample grid
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         tx_sh_q   <= 11'h7FF;
         tx_left_q <= 4'h0;
         tx_ph_q   <= 4'h0;
      end else if (tick) begin
         if (tx_active) begin
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == `SPSF_SMP_PER_BIT) begin
               tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
               tx_left_q <= tx_left_q - 4'h1;
            end
         end else if (ctrl2_q[`SPSF_C2_TE_BIT]) begin
            tx_ph_q <= 4'h0;
            if (pre_q) begin
               tx_sh_q   <= 11'h7FF;
               tx_left_q <= char_len;
            end else if (sbk_on) begin
               tx_sh_q   <= 11'h000;
               tx_left_q <= char_len;
            end else if (!flags_q.txe) begin
               // parity takes the top data bit when checking is on
               tx_left_q <= char_len;
               if (ctrl1_q[`SPSF_C1_M_BIT])
                  tx_sh_q <= {1'b1, ctrl1_q[`SPSF_C1_PE_BIT] &
                              (^tx_buf_q ^ ctrl1_q[`SPSF_C1_PT_BIT]), tx_buf_q, 1'b0};
               else if (ctrl1_q[`SPSF_C1_PE_BIT])
                  tx_sh_q <= {2'b11, ^tx_buf_q[6:0] ^ ctrl1_q[`SPSF_C1_PT_BIT],
                              tx_buf_q[6:0], 1'b0};
               else
                  tx_sh_q <= {2'b11, tx_buf_q, 1'b0};
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) txd_q <= 1'b1;
      else txd_q <= tx_active ? tx_sh_q[0] : 1'b1;
   end
   assign TXD_O = txd_q;

   // ==========================================================
   // checks
   a_status_read_data: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      st_rd |=> RDATA_O == $past(flags_q))
      else $error("status read returned wrong flags");
   a_txe_clear_seq: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      $fell(flags_q.txe) |-> $past(dat_wr) && $past(arm_q[7]))
      else $error("transmit-empty cleared without sequence");
   a_tc_when_idle: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      flags_q.txe && !tx_active && !pre_q && !sbk_on && !clr[6] |=> flags_q.tc)
      else $error("transmit-complete not set while idle");
   a_tc_clear_seq: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      $fell(flags_q.tc) |-> $past(arm_q[6])
         && $past(dat_wr || te_rise || (c2_wr && WDATA_I[`SPSF_C2_SBK_BIT])))
      else $error("transmit-complete cleared without sequence");
   a_rxf_on_load: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      rx_done && !rxf_eff |=> flags_q.rxf && rx_data_q != $past(rx_data_q) || flags_q.rxf)
      else $error("receive-full not set on load");
   a_rxf_clear_seq: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      $fell(flags_q.rxf) |-> $past(dat_rd) && $past(arm_q[5]))
      else $error("receive-full cleared without sequence");
   a_idle_once_only: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      $rose(flags_q.idle) |-> $past(allow_q) ##1 !allow_q)
      else $error("idle set without new character");
   a_overrun_discard: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      rx_done && rxf_eff |=> flags_q.ovr && $stable(rx_data_q))
      else $error("overrun did not keep old character");
   a_frame_with_rxf: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      $rose(flags_q.frame) |-> flags_q.rxf && $past(rx_done))
      else $error("framing error set apart from receive-full");
   a_parity_enabled: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      $rose(flags_q.par) |-> $past(ctrl1_q[`SPSF_C1_PE_BIT]) && flags_q.rxf && $past(rx_done))
      else $error("parity error without checking or load");
endmodule : spsf_top

/* File: spsf_remote.sv */
// remote serial transceiver model on the receive and transmit lines
module spsf_remote #(
   parameter int BIT_CYC = 16  // clock cycles per bit time
) (
   input  wire logic clk_i,
   input  wire logic txd_i,
   output logic      rxd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got_q;  // last byte taken off the transmit line
   // ==========================================================
   // frame driver: start, eight bits lsb first, stop, idle high after
   task automatic send(input logic [7:0] b, input logic stop_v, input logic glitch);
      logic v;
      begin
         for (int i = 0; i < 10; i++) begin
            v = (i == 0) ? 1'b0 : (i == 9) ? stop_v : b[i-1];
            for (int k = 0; k < BIT_CYC; k++) begin
               @(posedge clk_i);
               // one-cycle glitch late in a data bit keeps the majority intact
               // a low stop bit is held only over its sample window
               rxd_o <= (glitch && i == 3 && k == 9) ? ~v :
                        (i == 9 && !stop_v && k >= 10) ? 1'b1 : v;
            end
         end
      end
   endtask : send
   // ==========================================================
   // transmit line monitor, samples each bit near its middle
   initial begin
      rxd_o = 1'b1;
      got_q = 8'h00;
      forever begin
         @(posedge clk_i);
         if (txd_i === 1'b0) begin
            repeat (BIT_CYC / 2) @(posedge clk_i);
            for (int j = 0; j < 8; j++) begin
               repeat (BIT_CYC) @(posedge clk_i);
               got_q[j] = txd_i;
            end
            repeat (BIT_CYC) @(posedge clk_i);
         end
      end
   end
endmodule : spsf_remote

/* File: spsf_top_tb.sv */
// self-checking bench for the serial status flag block
`include "spsf_cfg.svh"
module spsf_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BC = 16;  // one clock per sample, sixteen samples a bit
   logic       sys_clk, rst, wr, rd, rxd, txd;
   logic [1:0] addr;
   logic [7:0] wdata, rdata;
   int         fail_count, n_checks, cyc;

   spsf_top #(.SAMPLE_DIV(1)) spsf_top_i (.SYS_CLK_I(sys_clk), .RST_I(rst), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RXD_I(rxd), .TXD_O(txd));
   spsf_remote #(.BIT_CYC(BC)) spsf_remote_i (.clk_i(sys_clk), .txd_i(txd), .rxd_o(rxd));

   // ==========================================================
   // clock, and a cycle ceiling so a hang still ends in a verdict
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         fail_count++;
         end_sim();
      end
   end
   // ==========================================================
   // bus tasks: every access ends one idle edge later, so no strobe is set twice at once
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      begin
         n_checks++;
         if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask : chk
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      begin
         addr  <= a;
         wdata <= d;
         wr    <= 1'b1;
         @(posedge sys_clk);
         wr    <= 1'b0;
         @(posedge sys_clk);
      end
   endtask : wr_reg
   task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, input logic [7:0] m);
      begin
         addr <= a;
         rd   <= 1'b1;
         @(posedge sys_clk);
         rd   <= 1'b0;
         #1;
         chk(rdata & m, exp);
         @(posedge sys_clk);
      end
   endtask : rd_chk
   task automatic bits(input int n);
      repeat (n * BC) @(posedge sys_clk);
   endtask : bits
   // ==========================================================
   // scenarios
   task automatic t_tx();
      begin
         wr_reg(`SPSF_OFF_DATA, 8'hA5);
         rd_chk(`SPSF_OFF_STATUS, `SPSF_FLAGS_RST, 8'hFF);
         wr_reg(`SPSF_OFF_DATA, 8'hA5);
         rd_chk(`SPSF_OFF_STATUS, 8'h00, 8'hFF);
         wr_reg(`SPSF_OFF_CTRL2, 8'h08);
         bits(25);
         chk(spsf_remote_i.got_q, 8'hA5);
         rd_chk(`SPSF_OFF_STATUS, 8'hC0, 8'hFF);
         wr_reg(`SPSF_OFF_CTRL2, 8'h09);
         rd_chk(`SPSF_OFF_STATUS, 8'h80, 8'hFF);
         wr_reg(`SPSF_OFF_CTRL2, 8'h08);
         bits(15);
         rd_chk(`SPSF_OFF_STATUS, 8'hC0, 8'hFF);
         wr_reg(`SPSF_OFF_CTRL2, 8'h00);
         wr_reg(`SPSF_OFF_CTRL2, 8'h08);
         rd_chk(`SPSF_OFF_STATUS, 8'h80, 8'hFF);
         bits(15);
         wr_reg(`SPSF_OFF_STATUS, 8'h3F);
         rd_chk(`SPSF_OFF_STATUS, 8'hC0, 8'hFF);
         $display("done transmit flags");
      end
   endtask : t_tx
   // one received frame: status with flags, data read clears them; idle bit is masked
   task automatic rx_case(input logic [7:0] c1, input logic [7:0] b, input logic stop_v,
                          input logic glitch, input logic [7:0] st, input logic [7:0] d);
      begin
         wr_reg(`SPSF_OFF_CTRL1, c1);
         spsf_remote_i.send(b, stop_v, glitch);
         rd_chk(`SPSF_OFF_STATUS, st, 8'hEF);
         rd_chk(`SPSF_OFF_DATA, d & 8'h7F, 8'h7F);
         rd_chk(`SPSF_OFF_STATUS, 8'hC0, 8'hEF);
         bits(12);
         $display("done receive case %h", b);
      end
   endtask : rx_case
   task automatic t_ovr();
      begin
         wr_reg(`SPSF_OFF_CTRL1, 8'h00);  // parity off, so only the overrun shows
         spsf_remote_i.send(8'h11, 1'b1, 1'b0);
         spsf_remote_i.send(8'h22, 1'b0, 1'b0);
         rd_chk(`SPSF_OFF_STATUS, 8'hE8, 8'hEF);
         rd_chk(`SPSF_OFF_DATA, 8'h11, 8'hFF);
         rd_chk(`SPSF_OFF_STATUS, 8'hC0, 8'hEF);
         $display("done overrun");
      end
   endtask : t_ovr
   task automatic t_idle();
      begin
         wr_reg(`SPSF_OFF_CTRL1, 8'h04);
         spsf_remote_i.send(8'h3C, 1'b1, 1'b0);
         rd_chk(`SPSF_OFF_STATUS, 8'hE0, 8'hEF);
         rd_chk(`SPSF_OFF_DATA, 8'h3C, 8'hFF);
         bits(8);
         rd_chk(`SPSF_OFF_STATUS, 8'hC0, 8'hFF);
         bits(3);
         rd_chk(`SPSF_OFF_STATUS, 8'hD0, 8'hFF);
         rd_chk(`SPSF_OFF_DATA, 8'h3C, 8'hFF);
         rd_chk(`SPSF_OFF_STATUS, 8'hC0, 8'hFF);
         bits(14);
         rd_chk(`SPSF_OFF_STATUS, 8'hC0, 8'hFF);
         wr_reg(`SPSF_OFF_CTRL1, 8'h00);
         spsf_remote_i.send(8'hFF, 1'b1, 1'b0);
         rd_chk(`SPSF_OFF_STATUS, 8'hE0, 8'hEF);
         rd_chk(`SPSF_OFF_DATA, 8'hFF, 8'hFF);
         bits(3);
         rd_chk(`SPSF_OFF_STATUS, 8'hD0, 8'hFF);
         $display("done idle line");
      end
   endtask : t_idle
   // ==========================================================
   // verdict, reached from the main sequence or the cycle ceiling
   task automatic end_sim();
      begin
         $display("checks=%0d mismatches=%0d", n_checks, fail_count);
         if (fail_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
         end else begin
            $display("MISMATCHES SEEN");
         end
         $finish;
      end
   endtask : end_sim
   // ==========================================================
   // main sequence
   initial begin
      rst        = 1'b1;
      addr       = 2'h0;
      wdata      = 8'h00;
      wr         = 1'b0;
      rd         = 1'b0;
      fail_count = 0;
      n_checks   = 0;
      cyc        = 0;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_tx();
      rx_case(8'h00, 8'h3C, 1'b1, 1'b0, 8'hE0, 8'h3C);
      rx_case(8'h00, 8'h3C, 1'b0, 1'b0, 8'hE2, 8'h3C);
      rx_case(8'h00, 8'h3C, 1'b1, 1'b1, 8'hE4, 8'h3C);
      rx_case(8'h02, 8'h03, 1'b1, 1'b0, 8'hE0, 8'h03);
      rx_case(8'h02, 8'h07, 1'b1, 1'b0, 8'hE1, 8'h07);
      rx_case(8'h03, 8'h07, 1'b1, 1'b0, 8'hE0, 8'h07);
      rx_case(8'h03, 8'h03, 1'b1, 1'b0, 8'hE1, 8'h03);
      t_ovr();
      t_idle();
      end_sim();
   end
endmodule : spsf_top_tb
